//--- shared/pmr_pkg.sv
// package: offsets, fields, reset values and carriers for the phy management register slice
`default_nettype none
package pmr_pkg;
  // ----------------------------------------------------------------
  // register offsets (management register numbers)
  // ----------------------------------------------------------------
  localparam logic [4:0] PMR_OFS_GIG_STATUS  = 5'h0A;
  localparam logic [4:0] PMR_OFS_MMD_CTRL    = 5'h0D;
  localparam logic [4:0] PMR_OFS_MMD_ADDATA  = 5'h0E;
  localparam logic [4:0] PMR_OFS_GIG_ABILITY = 5'h0F;
  localparam logic [4:0] PMR_OFS_PHY_CTRL    = 5'h10;
  // ----------------------------------------------------------------
  // reset values and the idle counter limit
  // ----------------------------------------------------------------
  localparam logic [15:0] PMR_RST_MMD_CTRL    = 16'h0000;
  localparam logic [15:0] PMR_RST_MMD_ADDR    = 16'h0000;
  localparam logic [15:0] PMR_RST_GIG_ABILITY = 16'hF000;
  localparam logic [15:0] PMR_RST_PHY_CTRL    = 16'h5048;
  localparam logic [7:0]  PMR_RST_IDLE_CNT    = 8'h00;
  localparam logic [7:0]  PMR_IDLE_CNT_MAX    = 8'hFF;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PMR_GS_FAULT   = 15;
  localparam int PMR_GS_MASTER  = 14;
  localparam int PMR_GS_LOC_OK  = 13;
  localparam int PMR_GS_REM_OK  = 12;
  localparam int PMR_GS_LP_FD   = 11;
  localparam int PMR_GS_LP_HD   = 10;
  localparam int PMR_MC_FUNC_HI = 15;
  localparam int PMR_MC_FUNC_LO = 14;
  localparam int PMR_MC_DEV_HI  = 4;
  localparam int PMR_PC_TXF_HI  = 15;
  localparam int PMR_PC_TXF_LO  = 14;
  localparam int PMR_PC_RXF_HI  = 13;
  localparam int PMR_PC_RXF_LO  = 12;
  localparam int PMR_PC_FORCE   = 10;
  localparam int PMR_PC_PWR_HI  = 9;
  localparam int PMR_PC_PWR_LO  = 8;
  localparam int PMR_PC_XO_HI   = 6;
  localparam int PMR_PC_XO_LO   = 5;
  localparam int PMR_PC_CLKDIS  = 4;
  localparam int PMR_PC_INV     = 1;
  localparam int PMR_PC_JABDIS  = 0;
  localparam logic [15:0] PMR_MC_WMASK = 16'hC01F;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMR_FN_ADDR    = 2'h0,
    PMR_FN_DATA    = 2'h1,
    PMR_FN_DATA_RW = 2'h2,
    PMR_FN_DATA_W  = 2'h3
  } pmr_func_e;
  localparam logic [1:0] PMR_PWR_ACTIVE  = 2'h2;
  localparam logic [1:0] PMR_PWR_PASSIVE = 2'h3;
  localparam logic [1:0] PMR_XO_MDI      = 2'h0;
  localparam logic [1:0] PMR_XO_MDIX     = 2'h1;
  localparam logic [3:0] PMR_DEPTH_C0    = 4'h3;
  localparam logic [3:0] PMR_DEPTH_C1    = 4'h4;
  localparam logic [3:0] PMR_DEPTH_C2    = 4'h6;
  localparam logic [3:0] PMR_DEPTH_C3    = 4'h8;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmr_req_s;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  devad;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pmr_mmd_s;
endpackage : pmr_pkg
`default_nettype wire

//--- rtl/pmr_regs.sv
// phy management register slice: gigabit status, mmd indirect access, ability, phy_specific_control
`timescale 1ns/1ns
`default_nettype none
module pmr_regs
  import pmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire pmr_req_s    mgmt_req,
  output var  logic [15:0] mgmt_rdata,
  output var  logic        mgmt_rvalid,
  input  wire logic        role_fault_evt,
  input  wire logic        role_resolved_master,
  input  wire logic        local_receiver_ok,
  input  wire logic        remote_receiver_ok,
  input  wire logic        partner_gig_full_duplex,
  input  wire logic        partner_gig_half_duplex,
  input  wire logic        idle_err_evt,
  input  wire logic        link_ok_raw,
  input  wire logic        speed_is_gig,
  input  wire logic        mac_is_gmii,
  input  wire logic        mac_is_sgmii,
  input  wire logic        mirror_mode,
  input  wire logic [15:0] mmd_rdata,
  output var  pmr_mmd_s    mmd_port,
  output var  logic        link_ok,
  output var  logic        tx_fifo_en,
  output var  logic [3:0]  tx_fifo_depth,
  output var  logic        rx_fifo_en,
  output var  logic [3:0]  rx_fifo_depth,
  output var  logic        sleep_active,
  output var  logic        sleep_passive,
  output var  logic        force_mdi,
  output var  logic        force_mdix,
  output var  logic        auto_crossover,
  output var  logic        clock_out_125m_en,
  output var  logic        tx_driver_invert,
  output var  logic        jabber_detect_en
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // fifo depth code to entries, shared by both directions
  function automatic logic [3:0] pmr_depth(input logic [1:0] code);
    logic [3:0] d;
    d = PMR_DEPTH_C0;
    case (code)
      2'h1:    d = PMR_DEPTH_C1;
      2'h2:    d = PMR_DEPTH_C2;
      2'h3:    d = PMR_DEPTH_C3;
      default: d = PMR_DEPTH_C0;
    endcase
    return d;
  endfunction : pmr_depth

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // flag, counter and the two writable control words
  logic        fault_reg;
  logic        fault_next;
  logic [7:0]  idle_cnt_reg;
  logic [7:0]  idle_cnt_next;
  logic [15:0] mmd_ctrl_reg;
  logic [15:0] mmd_ctrl_next;
  logic [15:0] phy_ctrl_reg;
  logic [15:0] phy_ctrl_next;
  // one address pointer per mmd, indexed by device address
  logic [15:0] mmd_addr_reg [32];

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // one compare per mapped offset; a miss matches nothing and reads zero
  wire logic       hit_status  = mgmt_req.addr == PMR_OFS_GIG_STATUS;
  wire logic       hit_ctrl    = mgmt_req.addr == PMR_OFS_MMD_CTRL;
  wire logic       hit_addata  = mgmt_req.addr == PMR_OFS_MMD_ADDATA;
  wire logic       hit_ability = mgmt_req.addr == PMR_OFS_GIG_ABILITY;
  wire logic       hit_phy     = mgmt_req.addr == PMR_OFS_PHY_CTRL;
  // function field and device address steer every indirect access
  wire pmr_func_e  func        = pmr_func_e'(mmd_ctrl_reg[PMR_MC_FUNC_HI:PMR_MC_FUNC_LO]);
  wire logic [4:0] devad       = mmd_ctrl_reg[PMR_MC_DEV_HI:0];
  wire logic       data_mode   = func != PMR_FN_ADDR;
  wire logic       ad_wr       = mgmt_req.wr & hit_addata;
  wire logic       ad_rd       = mgmt_req.rd & hit_addata;
  wire logic       addr_load   = ad_wr & ~data_mode;
  // post-increment on rd+wr for code 2, writes only for code 3
  wire logic       post_inc    = (ad_wr & (func == PMR_FN_DATA_RW || func == PMR_FN_DATA_W))
                               | (ad_rd & func == PMR_FN_DATA_RW);
  wire logic       status_rd   = mgmt_req.rd & hit_status;

  // ----------------------------------------------------------------
  // status flag and idle counter
  // ----------------------------------------------------------------
  // a fault arriving with the clearing read wins, so no event is lost
  assign fault_next = role_fault_evt | (fault_reg & ~status_rd);
  // saturate instead of wrapping so a busy line never reads as quiet
  assign idle_cnt_next = (idle_err_evt && idle_cnt_reg != PMR_IDLE_CNT_MAX)
                       ? idle_cnt_reg + 8'h01 : idle_cnt_reg;

  // latched flag, live levels, zero pad, then the counter
  wire logic [15:0] status_word = {fault_reg,
                                   role_resolved_master,
                                   local_receiver_ok,
                                   remote_receiver_ok,
                                   partner_gig_full_duplex,
                                   partner_gig_half_duplex,
                                   2'b00,
                                   idle_cnt_reg};

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // reserved control bits 13..5 stay zero
  assign mmd_ctrl_next = (mgmt_req.wr & hit_ctrl)
                       ? (mgmt_req.wdata & PMR_MC_WMASK) : mmd_ctrl_reg;
  // reserved control bits are stored and read back as written
  assign phy_ctrl_next = (mgmt_req.wr & hit_phy) ? mgmt_req.wdata : phy_ctrl_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // data mode returns what the extended set answers for the current pointer
  wire logic [15:0] addata_word = data_mode ? mmd_rdata : mmd_addr_reg[devad];
  wire logic [15:0] read_word   = hit_status  ? status_word
                                : hit_ctrl    ? mmd_ctrl_reg
                                : hit_addata  ? addata_word
                                : hit_ability ? PMR_RST_GIG_ABILITY
                                : hit_phy     ? phy_ctrl_reg
                                : 16'h0000;
  // last answer is held, so a slow host may sample it late
  wire logic [15:0] rdata_next  = mgmt_req.rd ? read_word : mgmt_rdata;
  wire logic        rvalid_next = mgmt_req.rd;

  // ----------------------------------------------------------------
  // phy_specific_control decode
  // ----------------------------------------------------------------
  // field slices of the control word
  wire logic [1:0] pwr_code = phy_ctrl_reg[PMR_PC_PWR_HI:PMR_PC_PWR_LO];
  wire logic [1:0] xo_code  = phy_ctrl_reg[PMR_PC_XO_HI:PMR_PC_XO_LO];
  wire logic [1:0] txf_code = phy_ctrl_reg[PMR_PC_TXF_HI:PMR_PC_TXF_LO];
  wire logic [1:0] rxf_code = phy_ctrl_reg[PMR_PC_RXF_HI:PMR_PC_RXF_LO];

  // ----------------------------------------------------------------
  // control output next values
  // ----------------------------------------------------------------
  // forced link only counts at gigabit speed, lower speeds show the real state
  wire logic       link_ok_next   = link_ok_raw
                                  | (phy_ctrl_reg[PMR_PC_FORCE] & speed_is_gig);
  // fifos sit in the path only where rates must be matched
  wire logic       tx_fifo_next   = (speed_is_gig & mac_is_gmii) | mac_is_sgmii;
  wire logic [3:0] tx_depth_next  = pmr_depth(txf_code);
  wire logic       rx_fifo_next   = mac_is_sgmii;
  wire logic [3:0] rx_depth_next  = pmr_depth(rxf_code);
  // reserved code 1 is treated as normal mode
  wire logic       sleep_act_next = pwr_code == PMR_PWR_ACTIVE;
  wire logic       sleep_pas_next = pwr_code == PMR_PWR_PASSIVE;
  // codes 2 and 3 both mean automatic, so the upper bit alone decides
  wire logic       mdi_next       = xo_code == PMR_XO_MDI;
  wire logic       mdix_next      = xo_code == PMR_XO_MDIX;
  wire logic       auto_xo_next   = xo_code[1];
  // clock pin keeps running unless software turns it off
  wire logic       clk_out_next   = ~phy_ctrl_reg[PMR_PC_CLKDIS];
  // inversion means nothing in mirror mode, so it is masked there
  wire logic       invert_next    = phy_ctrl_reg[PMR_PC_INV] & ~mirror_mode;
  wire logic       jabber_next    = ~phy_ctrl_reg[PMR_PC_JABDIS];

  // ----------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------
  // status flag, idle counter and the two writable words
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg    <= 1'b0;
      idle_cnt_reg <= PMR_RST_IDLE_CNT;
      mmd_ctrl_reg <= PMR_RST_MMD_CTRL;
      phy_ctrl_reg <= PMR_RST_PHY_CTRL;
    end else begin
      fault_reg    <= fault_next;
      idle_cnt_reg <= idle_cnt_next;
      mmd_ctrl_reg <= mmd_ctrl_next;
      phy_ctrl_reg <= phy_ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // per-mmd address pointers
  // ----------------------------------------------------------------
  // one process per pointer keeps every element single-driven
  // an increment lands after the access, which used the old pointer
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_ptr
      wire logic sel = devad == g[4:0];
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          mmd_addr_reg[g] <= PMR_RST_MMD_ADDR;
        end else if (sel & addr_load) begin
          mmd_addr_reg[g] <= mgmt_req.wdata;
        end else if (sel & post_inc) begin
          mmd_addr_reg[g] <= mmd_addr_reg[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // management answer
  // ----------------------------------------------------------------
  // one-cycle answer; unmapped offsets read zero
  // rvalid is one pulse per read request, never stretched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rdata  <= rdata_next;
      mgmt_rvalid <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // extended register port
  // ----------------------------------------------------------------
  // pointer is registered, so the selected address lags a pointer change by one
  // a data read right after a pointer change therefore needs one idle cycle first
  // address mode stays local, only data mode pulses the extended set
  wire logic        mmd_rd_next    = ad_rd & data_mode;
  wire logic        mmd_wr_next    = ad_wr & data_mode;
  // write data is held between writes, so the far side may sample it late
  wire logic [15:0] mmd_wdata_next = ad_wr ? mgmt_req.wdata : mmd_port.wdata;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mmd_port <= '0;
    end else begin
      mmd_port.rd    <= mmd_rd_next;
      mmd_port.wr    <= mmd_wr_next;
      mmd_port.devad <= devad;
      mmd_port.addr  <= mmd_addr_reg[devad];
      mmd_port.wdata <= mmd_wdata_next;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // every pin-level control leaves a flop, so no decode glitch reaches a pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_ok           <= 1'b0;
      tx_fifo_en        <= 1'b0;
      tx_fifo_depth     <= PMR_DEPTH_C1;
      rx_fifo_en        <= 1'b0;
      rx_fifo_depth     <= PMR_DEPTH_C1;
      sleep_active      <= 1'b0;
      sleep_passive     <= 1'b0;
      force_mdi         <= 1'b0;
      force_mdix        <= 1'b0;
      auto_crossover    <= 1'b1;
      clock_out_125m_en <= 1'b1;
      tx_driver_invert  <= 1'b0;
      jabber_detect_en  <= 1'b1;
    end else begin
      link_ok           <= link_ok_next;
      tx_fifo_en        <= tx_fifo_next;
      tx_fifo_depth     <= tx_depth_next;
      rx_fifo_en        <= rx_fifo_next;
      rx_fifo_depth     <= rx_depth_next;
      sleep_active      <= sleep_act_next;
      sleep_passive     <= sleep_pas_next;
      force_mdi         <= mdi_next;
      force_mdix        <= mdix_next;
      auto_crossover    <= auto_xo_next;
      clock_out_125m_en <= clk_out_next;
      tx_driver_invert  <= invert_next;
      jabber_detect_en  <= jabber_next;
    end
  end

endmodule : pmr_regs
`default_nettype wire

//--- tb/pmr_regs_chk.sv
// checker: port-level timing properties of the management register slice
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_chk
  import pmr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire pmr_req_s    mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        role_fault_evt,
  input wire logic        link_ok_raw,
  input wire logic        speed_is_gig,
  input wire logic        mac_is_gmii,
  input wire logic        mac_is_sgmii,
  input wire logic        mirror_mode,
  input wire pmr_mmd_s    mmd_port,
  input wire logic        link_ok,
  input wire logic        tx_fifo_en,
  input wire logic        rx_fifo_en,
  input wire logic        force_mdi,
  input wire logic        force_mdix,
  input wire logic        auto_crossover,
  input wire logic        tx_driver_invert
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // request decodes, shared by several properties
  wire logic rd_st = mgmt_req.rd && (mgmt_req.addr == PMR_OFS_GIG_STATUS);
  wire logic rd_ab = mgmt_req.rd && (mgmt_req.addr == PMR_OFS_GIG_ABILITY);
  wire logic wr_ad = mgmt_req.wr && (mgmt_req.addr == PMR_OFS_MMD_ADDATA);
  wire logic rd_ad = mgmt_req.rd && (mgmt_req.addr == PMR_OFS_MMD_ADDATA);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_flt_set; role_fault_evt ##1 (rd_st && !role_fault_evt) |=> mgmt_rdata[15];
  endproperty
  a_flt_set: assert property (p_flt_set) else $error("fault flag lost");
  // two clean reads in a row: the second must see the flag cleared
  property p_flt_clr; (rd_st && !role_fault_evt) [*2] |=> !mgmt_rdata[15]; endproperty
  a_flt_clr: assert property (p_flt_clr) else $error("fault flag stuck");
  property p_ab; rd_ab |=> mgmt_rdata == 16'hF000; endproperty
  a_ab: assert property (p_ab) else $error("ability word wrong");
  property p_lnk_up; link_ok_raw |=> link_ok; endproperty
  a_lnk_up: assert property (p_lnk_up) else $error("link lost");
  property p_lnk_dn; !link_ok_raw && !speed_is_gig |=> !link_ok; endproperty
  a_lnk_dn: assert property (p_lnk_dn) else $error("link forced off gigabit");
  property p_inv; mirror_mode |=> !tx_driver_invert; endproperty
  a_inv: assert property (p_inv) else $error("invert in mirror mode");
  property p_xo; $onehot({force_mdi, force_mdix, auto_crossover}); endproperty
  a_xo: assert property (p_xo) else $error("crossover not one-hot");
  property p_txf; !(speed_is_gig && mac_is_gmii) && !mac_is_sgmii |=> !tx_fifo_en;
  endproperty
  a_txf: assert property (p_txf) else $error("tx fifo on");
  property p_rxf; !mac_is_sgmii |=> !rx_fifo_en; endproperty
  a_rxf: assert property (p_rxf) else $error("rx fifo on");
  // an mmd write pulse needs an address/data write one cycle before
  property p_mwr; mmd_port.wr |-> $past(wr_ad) && (mmd_port.wdata == $past(mgmt_req.wdata));
  endproperty
  a_mwr: assert property (p_mwr) else $error("stray mmd write");
  // an mmd read pulse needs an address/data read one cycle before
  property p_mrd; mmd_port.rd |-> $past(rd_ad); endproperty
  a_mrd: assert property (p_mrd) else $error("stray mmd read");
endmodule : pmr_regs_chk
bind pmr_regs pmr_regs_chk u_chk (.mclk(mclk), .arst_n(arst_n), .mgmt_req(mgmt_req),
  .mgmt_rdata(mgmt_rdata), .role_fault_evt(role_fault_evt), .link_ok_raw(link_ok_raw),
  .speed_is_gig(speed_is_gig), .mac_is_gmii(mac_is_gmii), .mac_is_sgmii(mac_is_sgmii),
  .mirror_mode(mirror_mode), .mmd_port(mmd_port), .link_ok(link_ok), .tx_fifo_en(tx_fifo_en),
  .rx_fifo_en(rx_fifo_en), .force_mdi(force_mdi), .force_mdix(force_mdix),
  .auto_crossover(auto_crossover), .tx_driver_invert(tx_driver_invert));
`default_nettype wire

//--- tb/pmr_mmd_model.sv
// model of the extended register set behind the mmd indirect port
`timescale 1ns/1ns
`default_nettype none
module pmr_mmd_model
  import pmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire pmr_mmd_s    mmd_port,
  output var  logic [15:0] mmd_rdata
);
  logic [15:0] mem [0:1023];
  wire  logic [9:0] idx = {mmd_port.devad, mmd_port.addr[4:0]};
  // unwritten words hold a pattern, so a stale zero never passes
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'hA5A5 ^ 16'(i);
  // data follows device and pointer at once; writes land on the pulse
  assign mmd_rdata = mem[idx];
  always @(posedge mclk) if (mmd_port.wr) mem[idx] <= mmd_port.wdata;
endmodule : pmr_mmd_model
`default_nettype wire

//--- tb/pmr_regs_tb.sv
// self-checking bench for the phy management register slice
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pmr_regs_tb
  import pmr_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  pmr_req_s    req = '0;
  logic [11:0] iv = '0; // fault, five live bits, idle, raw, gig, gmii, sgmii, mirror
  logic [15:0] rdata, mmd_rdata, d, exp_v;
  logic        rvalid, link_ok, tx_fifo_en, rx_fifo_en, sleep_active, sleep_passive;
  logic        force_mdi, force_mdix, auto_crossover, clk_en, invert, jab_en;
  logic [3:0]  tx_depth, rx_depth;
  logic [3:0]  dep [4];
  logic [7:0]  cnt;
  pmr_mmd_s    mmd_port;
  logic [15:0] exp_q [$];
  int          errors = 0;
  int          total_checks = 0;
  pmr_regs dut (.mclk(mclk), .arst_n(arst_n), .mgmt_req(req), .mgmt_rdata(rdata),
    .mgmt_rvalid(rvalid), .role_fault_evt(iv[11]), .role_resolved_master(iv[10]),
    .local_receiver_ok(iv[9]), .remote_receiver_ok(iv[8]), .partner_gig_full_duplex(iv[7]),
    .partner_gig_half_duplex(iv[6]), .idle_err_evt(iv[5]), .link_ok_raw(iv[4]),
    .speed_is_gig(iv[3]), .mac_is_gmii(iv[2]), .mac_is_sgmii(iv[1]), .mirror_mode(iv[0]),
    .mmd_rdata(mmd_rdata), .mmd_port(mmd_port), .link_ok(link_ok), .tx_fifo_en(tx_fifo_en),
    .tx_fifo_depth(tx_depth), .rx_fifo_en(rx_fifo_en), .rx_fifo_depth(rx_depth),
    .sleep_active(sleep_active), .sleep_passive(sleep_passive), .force_mdi(force_mdi),
    .force_mdix(force_mdix), .auto_crossover(auto_crossover), .clock_out_125m_en(clk_en),
    .tx_driver_invert(invert), .jabber_detect_en(jab_en));
  pmr_mmd_model u_mmd (.mclk(mclk), .mmd_port(mmd_port), .mmd_rdata(mmd_rdata));
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // bus tasks: entered and left 1 ns after a rising edge
  // ----------------------------------------------------------------
  task automatic op(input logic r, input logic w, input logic [4:0] a, input logic [15:0] v);
    req = '{rd: r, wr: w, addr: a, wdata: v};
    @(posedge mclk);
    #1;
  endtask : op
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    op(1'b0, 1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b1, 1'b0, a, 16'h0000);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 5'h00, 16'h0000);
  endtask : idle
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // read answers are scored in order against the notes the driver left
  always @(negedge mclk) if (rvalid === 1'b1) begin
    exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
    `CHK("read data", exp_v, rdata)
  end
  // hang guard
  initial begin
    #200000 errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h146BC8EF));
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    // reset contents, an unmapped place and a write to the read-only word
    rd(PMR_OFS_GIG_STATUS, 16'h0000);
    rd(PMR_OFS_MMD_CTRL, 16'h0000);
    rd(PMR_OFS_PHY_CTRL, 16'h5048);
    rd(5'h1F, 16'h0000);
    wr(PMR_OFS_GIG_ABILITY, 16'h0FFF);
    rd(PMR_OFS_GIG_ABILITY, 16'hF000);
    `CHK("depths", 8'h44, {tx_depth, rx_depth})
    `CHK("pins", 3'b111, {auto_crossover, clk_en, jab_en})
    // latched fault, live status bits, saturating idle count
    cnt = 8'h00;
    for (int i = 0; i < 5; i++) begin
      iv[10:6] = 5'($urandom);
      iv[11] = i[0];
      iv[5] = 1'b1;
      idle((i == 4) ? 250 : i + 1);
      cnt = (i == 4) ? 8'hFF : cnt + 8'(i + 1);
      iv[11] = 1'b0;
      iv[5] = 1'b0;
      rd(PMR_OFS_GIG_STATUS, {i[0], iv[10:6], 2'b00, cnt});
      rd(PMR_OFS_GIG_STATUS, {1'b0, iv[10:6], 2'b00, cnt});
    end
    // indirect access: pointer load, every function code, own pointer per device
    wr(PMR_OFS_MMD_CTRL, 16'h001F);
    wr(PMR_OFS_MMD_ADDATA, 16'h0005);
    wr(PMR_OFS_MMD_CTRL, 16'h801F);
    wr(PMR_OFS_MMD_ADDATA, 16'h1234);
    wr(PMR_OFS_MMD_ADDATA, 16'h5678);
    wr(PMR_OFS_MMD_CTRL, 16'h001F);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h0007);
    wr(PMR_OFS_MMD_ADDATA, 16'h0005);
    wr(PMR_OFS_MMD_CTRL, 16'h401F);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h1234);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h1234);
    wr(PMR_OFS_MMD_CTRL, 16'hC01F);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h1234);
    wr(PMR_OFS_MMD_ADDATA, 16'h9ABC);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h5678);
    wr(PMR_OFS_MMD_CTRL, 16'h801F);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h5678);
    wr(PMR_OFS_MMD_CTRL, 16'h001F);
    idle(1);
    rd(PMR_OFS_MMD_ADDATA, 16'h0007);
    wr(PMR_OFS_MMD_CTRL, 16'h3FE2);
    rd(PMR_OFS_MMD_CTRL, 16'h0002);
    rd(PMR_OFS_MMD_ADDATA, 16'h0000);
    // control word: all power and crossover codes, random fifo and pin states
    dep = '{PMR_DEPTH_C0, PMR_DEPTH_C1, PMR_DEPTH_C2, PMR_DEPTH_C3};
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      d[9:8] = i[1:0];
      d[6:5] = i[2:1];
      iv[4:0] = 5'($urandom);
      wr(PMR_OFS_PHY_CTRL, d);
      rd(PMR_OFS_PHY_CTRL, d);
      `CHK("depths", {dep[d[15:14]], dep[d[13:12]]}, {tx_depth, rx_depth})
      `CHK("fifo", {(iv[3] & iv[2]) | iv[1], iv[1]}, {tx_fifo_en, rx_fifo_en})
      `CHK("link", iv[4] | (d[10] & iv[3]), link_ok)
      `CHK("sleep", {d[9:8] == 2'h2, d[9:8] == 2'h3}, {sleep_active, sleep_passive})
      `CHK("xo", {d[6:5] == 2'h0, d[6:5] == 2'h1, d[6]}, {force_mdi, force_mdix,
        auto_crossover})
      `CHK("pins", {~d[4], d[1] & ~iv[0], ~d[0]}, {clk_en, invert, jab_en})
    end
    // second reset in mid-run restores the control word
    idle(1);
    arst_n = 1'b0;
    idle(2);
    arst_n = 1'b1;
    rd(PMR_OFS_PHY_CTRL, 16'h5048);
    idle(2);
    `CHK("reads answered", 0, exp_q.size())
    complete_run();
  end
endmodule : pmr_regs_tb
`default_nettype wire
